/* hdl/sstt_consts.vh */
// Constants for the spin-synchronous thrust timing unit
// Functional notes
// R01: Spin-period count runs from one sensor pulse to the next, then is stored.
// R02: Period counter, fast counter and comparator are eleven bits wide.
// R03: Counting rate gives at least 1000 counts per revolution, 0.1 percent resolution.
// R04: Fast counter advances at a fixed multiple of the period counting rate.
// R05: Comparator emits one step pulse when fast count equals stored period.
// R06: Step pulse returns the fast counter to zero so steps recur evenly.
// R07: Multiple 128 gives 128 steps per revolution, about 2.81 degrees each.
// R08: Seven-bit angle counter counts step pulses since last sensor pulse.
// R09: Angle counter clears whenever a new period count is stored.
// R10: Each valve switches on and off at angle counts chosen by mode.
// R11: Thrust start timing allows precession in any of four directions.
// R12: Two pulse lengths: 60 and 6 degrees of spin rotation.
// R13: Counting clock is the subsystem clock divided by 128.
// R14: Rate sized for minimum period count 1024 at multiple 128, near 13.1 kc.
// R15: Closed loop triggers once only on positive-to-negative error zero crossing.
// R16: Acquisition triggers suppressed inside the 1.2 degree deadzone.
// R17: Fine channel fires nothing below its 0.25 degree deadzone.
// R18: Closed loop fires in the direction that reduces pointing error.
// R19: Six-degree pulses start 27 degrees later to share the thrust centre.
// R20: Each step is two pulses with centres 143.6 degrees apart.
`ifndef SSTT_CONSTS_VH
`define SSTT_CONSTS_VH
`define SSTT_PER_W 11
`define SSTT_ANG_W 7
`define SSTT_DIV_RATIO 128
`define SSTT_FAST_MULT 128
`define SSTT_MIN_COUNT 1000
`define SSTT_SUB_CLK_HZ 1677721
`define SSTT_DEG_PER_STEP_X100 281
// Angle counts in steps of 2.8125 degrees (360/128)
`define SSTT_LONG_STEPS 7'h15
`define SSTT_SHORT_STEPS 7'h02
`define SSTT_SHORT_DELAY 7'h0A
`define SSTT_SECOND_OFS 7'h33
`define SSTT_JET1_OFS 7'h15
`define SSTT_QUARTER 7'h20
`define SSTT_HALF 7'h40
`define SSTT_THREE_Q 7'h60
`define SSTT_LAST_STEP 7'h7F
// Precession directions
`define SSTT_DIR_TOWARD 2'h0
`define SSTT_DIR_AWAY 2'h1
`define SSTT_DIR_CONE_P 2'h2
`define SSTT_DIR_CONE_N 2'h3
// Loop modes
`define SSTT_MODE_OPEN 2'h0
`define SSTT_MODE_ACQ 2'h1
`define SSTT_MODE_FINE 2'h2
`endif

/* hdl/sstt_sync.v */
// Three-stage input synchroniser with agreement-based change detection
`timescale 1ns/1ns
`default_nettype none
module sstt_sync (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // Asynchronous input and clean outputs
    input wire async_i,
    output reg level_o,
    output wire rise_o,
    output wire fall_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // First stage feeds only the second; change counts once stages two and three agree
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
    assign rise_o = (s2_q == s3_q) && s3_q && !level_o;
    assign fall_o = (s2_q == s3_q) && !s3_q && level_o;
endmodule // sstt_sync
`default_nettype wire

/* hdl/sstt_timing.v */
// Spin-synchronous thrust timing unit: period measure, angle steps, jet gating
`timescale 1ns/1ns
`default_nettype none
`include "sstt_consts.vh"
module sstt_timing #(
    parameter PER_W = `SSTT_PER_W,
    parameter ANG_W = `SSTT_ANG_W,
    parameter DIV_RATIO = `SSTT_DIV_RATIO,
    parameter FAST_MULT = `SSTT_FAST_MULT
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_i,
    // Sensor and error-detector pins
    input wire sun_pulse_i,
    input wire err_neg_i,
    input wire acq_level_ok_i,
    input wire fine_level_ok_i,
    // Control levels
    input wire [1:0] loop_mode_i,
    input wire [1:0] direction_i,
    input wire short_pulse_i,
    input wire fire_en_i,
    // Valve drives and status
    output reg jet1_o,
    output reg jet2_o,
    output reg [PER_W-1:0] period_o,
    output reg [ANG_W-1:0] angle_o,
    output reg period_valid_o,
    output reg step_o
);
    localparam DIV_W = 8;
    localparam integer DIV_LAST_I = DIV_RATIO - 1;
    localparam integer FAST_LAST_I = DIV_RATIO / FAST_MULT - 1;
    localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_I[DIV_W-1:0];
    localparam [DIV_W-1:0] FAST_LAST = FAST_LAST_I[DIV_W-1:0];
    localparam [PER_W-1:0] PER_MAX = {PER_W{1'b1}};
    localparam ST_IDLE = 2'h0;
    localparam ST_COUNT = 2'h1;
    localparam ST_RUN = 2'h2;

    wire sun_rise;
    wire err_fall;
    wire acq_ok;
    wire fine_ok;
    wire err_lvl;

    // All sensor and error-detector pins come in through three-flop synchronisers; control levels are used directly
    sstt_sync u_sun (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(sun_pulse_i),
        .level_o(), .rise_o(sun_rise), .fall_o());
    // Falling of the positive flag is the positive-to-negative crossing
    sstt_sync u_err (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(err_neg_i),
        .level_o(err_lvl), .rise_o(), .fall_o(err_fall)); // see R15
    sstt_sync u_acq (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(acq_level_ok_i),
        .level_o(acq_ok), .rise_o(), .fall_o());
    sstt_sync u_fine (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .async_i(fine_level_ok_i),
        .level_o(fine_ok), .rise_o(), .fall_o());

    reg [DIV_W-1:0] div_q;
    reg [1:0] state_q;
    reg [PER_W-1:0] per_cnt_q;
    reg [PER_W-1:0] fast_cnt_q;
    reg armed_q;
    wire ref_pulse;
    wire trig;
    wire slow_tick;
    wire fast_tick;

    // Divider: slow tick every DIV_RATIO clocks, fast tick FAST_MULT times as often
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            div_q <= {DIV_W{1'b0}};
        end else if (div_q == DIV_LAST) begin
            div_q <= {DIV_W{1'b0}}; // see R13
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign slow_tick = (div_q == DIV_LAST); // see R13 R03 R14
    assign fast_tick = ((div_q & FAST_LAST) == FAST_LAST); // see R04

    // Trigger source: none in open loop, gated zero crossing in closed loop; sun sensor gives the reference
    assign trig = (loop_mode_i == `SSTT_MODE_ACQ) ? (err_fall && acq_ok) : // see R16
                  (loop_mode_i == `SSTT_MODE_FINE) ? (err_fall && fine_ok) : // see R17
                  1'b0;
    assign ref_pulse = sun_rise;

    // Period measurement, sensor to sensor
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            per_cnt_q <= {PER_W{1'b0}};
            period_o <= {PER_W{1'b0}};
            period_valid_o <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (ref_pulse) begin
                        per_cnt_q <= {PER_W{1'b0}}; // see R01
                        state_q <= ST_COUNT;
                    end
                end
                ST_COUNT, ST_RUN: begin
                    if (ref_pulse) begin
                        period_o <= per_cnt_q; // see R01 R02
                        period_valid_o <= (per_cnt_q != {PER_W{1'b0}});
                        per_cnt_q <= {PER_W{1'b0}};
                        state_q <= ST_RUN;
                    end else if (slow_tick && per_cnt_q != PER_MAX) begin
                        per_cnt_q <= per_cnt_q + 11'h001; // Saturates on a stalled spin
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Fast counter and comparator; step restarts the fast count
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            fast_cnt_q <= {PER_W{1'b0}};
            step_o <= 1'b0;
            angle_o <= {ANG_W{1'b0}};
        end else begin
            step_o <= 1'b0;
            if (ref_pulse) begin
                fast_cnt_q <= {PER_W{1'b0}};
                angle_o <= {ANG_W{1'b0}}; // see R09
                // A step due on the sensor edge still counts, so a turn keeps all its steps
                step_o <= period_valid_o && fast_tick &&
                          (fast_cnt_q + 11'h001 >= period_o); // see R05 R07
            end else if (period_valid_o && fast_tick) begin
                if (fast_cnt_q + 11'h001 >= period_o) begin
                    fast_cnt_q <= {PER_W{1'b0}}; // see R05 R06
                    step_o <= 1'b1;
                    angle_o <= angle_o + 7'h01; // see R07 R08
                end else begin
                    fast_cnt_q <= fast_cnt_q + 11'h001;
                end
            end
        end
    end

    // Firing window: start angle per direction, offset for short pulse, length per short-pulse select
    wire [ANG_W-1:0] dir_ofs;
    wire [ANG_W-1:0] len;
    wire [ANG_W-1:0] start1;
    wire [ANG_W-1:0] start2;
    wire [ANG_W-1:0] rel1;
    wire [ANG_W-1:0] rel2;
    // Closed loop uses the direction that points the axis back at the line of sight
    wire [1:0] dir_eff = (loop_mode_i == `SSTT_MODE_OPEN) ? direction_i
                                                         : `SSTT_DIR_TOWARD; // see R18
    assign dir_ofs = (dir_eff == `SSTT_DIR_TOWARD) ? 7'h00 :
                     (dir_eff == `SSTT_DIR_AWAY) ? `SSTT_HALF :
                     (dir_eff == `SSTT_DIR_CONE_P) ? `SSTT_QUARTER :
                     `SSTT_THREE_Q; // see R11
    assign len = short_pulse_i ? `SSTT_SHORT_STEPS : `SSTT_LONG_STEPS; // see R12
    assign start1 = `SSTT_JET1_OFS + dir_ofs +
                    (short_pulse_i ? `SSTT_SHORT_DELAY : 7'h00); // see R19
    assign start2 = start1 + `SSTT_SECOND_OFS; // see R20
    assign rel1 = angle_o - start1;
    assign rel2 = angle_o - start2;

    // Arm: open loop arms on each period, closed loop on each qualified trigger
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (!fire_en_i) begin
            armed_q <= 1'b0;
        end else if (loop_mode_i == `SSTT_MODE_OPEN) begin
            armed_q <= period_valid_o;
        end else if (trig) begin
            armed_q <= period_valid_o;
        end else if (angle_o == `SSTT_LAST_STEP && step_o) begin
            armed_q <= 1'b0; // One pair per closed-loop trigger
        end
    end

    // Valve gating from the instantaneous angle count
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            jet1_o <= 1'b0;
            jet2_o <= 1'b0;
        end else begin
            jet1_o <= armed_q && (rel1 < len); // see R10
            // Only the closed loop waits for a negative error; open loop fires both jets
            jet2_o <= armed_q && (rel2 < len) &&
                      (loop_mode_i == `SSTT_MODE_OPEN || !err_lvl); // see R10
        end
    end
endmodule // sstt_timing
`default_nettype wire

/* tb/sstt_timing_checker.sv */
// Port checker for the spin-synchronous thrust timing unit
`timescale 1ns/1ns
`default_nettype none
`include "sstt_consts.vh"
module sstt_timing_checker #(
    parameter PER_W = `SSTT_PER_W,
    parameter ANG_W = `SSTT_ANG_W
) (
    // Clock, reset and controls
    input wire sys_clk_i,
    input wire rst_i,
    input wire fire_en_i,
    input wire [1:0] loop_mode_i,
    input wire [1:0] direction_i,
    input wire short_pulse_i,
    // Outputs watched
    input wire jet1_o,
    input wire jet2_o,
    input wire [PER_W-1:0] period_o,
    input wire [ANG_W-1:0] angle_o,
    input wire period_valid_o,
    input wire step_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Jet 1 opening angle; direction picks a quarter turn offset
    function automatic [6:0] st1(input [1:0] d, input s);
        st1 = `SSTT_JET1_OFS + (s ? `SSTT_SHORT_DELAY : 7'h00) + `SSTT_QUARTER * {d[0], d[1]};
    endfunction
    // Angle lies inside an arc, modulo one revolution
    function automatic arc(input [6:0] a, input [6:0] st, input s);
        logic [6:0] df;
        df = a - st;
        arc = df < (s ? `SSTT_SHORT_STEPS : `SSTT_LONG_STEPS);
    endfunction
    // Controls held long enough that the registered jets have caught up
    sequence open_held;
        (fire_en_i && loop_mode_i == `SSTT_MODE_OPEN && period_valid_o && $stable(direction_i)
            && $stable(short_pulse_i) && $stable(fire_en_i) && $stable(loop_mode_i))[*3];
    endsequence
    // Closed loop held with a fixed pulse length
    sequence closed_held;
        (loop_mode_i != `SSTT_MODE_OPEN && $stable(loop_mode_i)
            && $stable(short_pulse_i))[*3];
    endsequence
    step_one_cycle_a: assert property (step_o |=> !step_o)
        else $error("step pulse longer than one cycle");
    step_needs_valid_a: assert property (step_o |-> period_valid_o)
        else $error("step without a stored period");
    angle_counts_up_a: assert property (
        $changed(angle_o) |-> angle_o == 7'h00 || angle_o == $past(angle_o) + 7'h01)
        else $error("angle moved by other than one step");
    angle_on_step_a: assert property (
        $changed(angle_o) && angle_o != 7'h00 |-> step_o || $past(step_o))
        else $error("angle moved without a step");
    angle_clear_a: assert property ($changed(period_o) |-> angle_o == 7'h00)
        else $error("angle not cleared on new period");
    jet1_gate_a: assert property (
        open_held |-> jet1_o == arc($past(angle_o), st1(direction_i, short_pulse_i),
            short_pulse_i))
        else $error("jet 1 level wrong for angle");
    jet2_gate_a: assert property (
        open_held |-> jet2_o == arc($past(angle_o),
            st1(direction_i, short_pulse_i) + `SSTT_SECOND_OFS, short_pulse_i))
        else $error("jet 2 level wrong for angle");
    jets_held_off_a: assert property (
        !fire_en_i && !$past(fire_en_i) && !$past(fire_en_i, 2) |-> !jet1_o && !jet2_o)
        else $error("jet open while firing disabled");
    closed_dir_a: assert property (
        closed_held ##0 jet1_o |-> arc($past(angle_o),
            st1(`SSTT_DIR_TOWARD, short_pulse_i), short_pulse_i))
        else $error("closed loop jet 1 outside the error reducing arc");
endmodule // sstt_timing_checker
`default_nettype wire

/* tb/sstt_sun_model.sv */
// Sun sensor model: one short pulse per revolution
`timescale 1ns/1ns
`default_nettype none
module sstt_sun_model (
    // Clock, reset and revolution length
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] rev_clks_i,
    // Sensor pin
    output logic sun_o
);
    int cnt = 0;
    // Pulse spans 8 clocks so the synchroniser always sees it; low between crossings
    always @(posedge clk_i) begin
        if (rst_i || cnt >= rev_clks_i - 1) cnt <= 0;
        else cnt <= cnt + 1;
        sun_o <= #1 !rst_i && cnt < 8;
    end
endmodule // sstt_sun_model
`default_nettype wire

/* tb/tb_spin_sync_thrust_timing.sv */
// Testbench for the spin-synchronous thrust timing unit
`timescale 1ns/1ns
`default_nettype none
`include "sstt_consts.vh"
module tb_spin_sync_thrust_timing;
    typedef struct packed {logic [7:0] p; logic [1:0] dir; logic sh; logic [6:0] len;} sstt_row_t;
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic err_neg = 1'b1, acq_ok = 1'b1, fine_ok = 1'b1, sh = 1'b0, fire = 1'b0, cnt_on = 1'b0;
    logic [1:0] mode = 2'h0, dir = 2'h0;
    logic sun, jet1, jet2, pvalid, step;
    logic [10:0] period;
    logic [6:0] angle;
    logic [31:0] rev = 32'h800;
    int num_errors = 0, n_checks = 0, cyc = 0, n_step = 0, n_j1 = 0, n_j2 = 0;
    // Period count, direction, short pulses, expected arc length in steps
    sstt_row_t rows [8] = '{'{8'h10, 2'h0, 1'b0, 7'h15}, '{8'h11, 2'h1, 1'b0, 7'h15},
        '{8'h12, 2'h2, 1'b0, 7'h15}, '{8'h13, 2'h3, 1'b0, 7'h15}, '{8'h14, 2'h0, 1'b1, 7'h02},
        '{8'h15, 2'h1, 1'b1, 7'h02}, '{8'h16, 2'h2, 1'b1, 7'h02}, '{8'h17, 2'h3, 1'b1, 7'h02}};
    sstt_sun_model i_sun (.clk_i(sys_clk_i), .rst_i(rst_i), .rev_clks_i(rev), .sun_o(sun));
    sstt_timing i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sun_pulse_i(sun),
        .err_neg_i(err_neg), .acq_level_ok_i(acq_ok), .fine_level_ok_i(fine_ok),
        .loop_mode_i(mode), .direction_i(dir), .short_pulse_i(sh), .fire_en_i(fire),
        .jet1_o(jet1), .jet2_o(jet2), .period_o(period), .angle_o(angle),
        .period_valid_o(pvalid), .step_o(step));
    always #5 sys_clk_i = ~sys_clk_i;
    // Cycle ceiling, error zero crossings every 512 clocks, window counters
    always @(posedge sys_clk_i) begin
        cyc++;
        err_neg <= #1 cyc[9];
        if (cnt_on) begin
            n_step += step;
            n_j1 += jet1;
            n_j2 += jet2;
        end
        if (cyc == 95000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    // Counts over exactly n edges
    task automatic window(input int n);
        n_step = 0;
        n_j1 = 0;
        n_j2 = 0;
        cnt_on = 1'b1;
        tick(n);
        cnt_on = 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        tick(3);
        rst_i = 1'b0;
        chk(pvalid, 1'b0);
        fire = 1'b1;
        // Table: period measure, steps per turn, jet arcs for each direction and length
        foreach (rows[i]) begin
            rev = 32'(rows[i].p) * 128;
            dir = rows[i].dir;
            sh = rows[i].sh;
            tick(2 * rev);
            chk(period, rows[i].p);
            window(rev);
            chk(n_step, 128);
            chk(n_j1, 32'(rows[i].len) * 32'(rows[i].p));
            chk(n_j2, 32'(rows[i].len) * 32'(rows[i].p));
            $display("row %0d done", i);
        end
        // Firing disabled; registered jets need two edges to follow, gate settles meanwhile
        fire = 1'b0;
        acq_ok = 1'b0;
        tick(3);
        window(rev);
        chk(n_j1 + n_j2, 0);
        // Acquisition gate shut while the fine gate stays open
        fire = 1'b1;
        mode = `SSTT_MODE_ACQ;
        window(rev);
        chk(n_j1 + n_j2, 0);
        // Fine gate shut while acquisition still ignores it, so no trigger slips through
        fine_ok = 1'b0;
        tick(8);
        mode = `SSTT_MODE_FINE;
        acq_ok = 1'b1;
        window(rev);
        chk(n_j1 + n_j2, 0);
        mode = `SSTT_MODE_ACQ;
        window(2 * rev);
        chk(n_j1 != 0, 1'b1);
        $display("hand tests done");
        // Reset in mid-run clears the outputs, then the period is measured afresh
        rst_i = 1'b1;
        tick(3);
        rst_i = 1'b0;
        chk(period, 11'h000);
        chk(angle, 7'h00);
        chk(jet1 | jet2, 1'b0);
        tick(2 * rev);
        chk(period, 32'(rows[7].p));
        $display("reset test done");
        end_sim();
    end
endmodule // tb_spin_sync_thrust_timing
bind sstt_timing sstt_timing_checker #(.PER_W(PER_W), .ANG_W(ANG_W)) i_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .fire_en_i(fire_en_i), .loop_mode_i(loop_mode_i),
    .direction_i(direction_i), .short_pulse_i(short_pulse_i), .jet1_o(jet1_o), .jet2_o(jet2_o),
    .period_o(period_o), .angle_o(angle_o), .period_valid_o(period_valid_o), .step_o(step_o));
`default_nettype wire
